// >>> inc/htwc_pkg.sv
// shared constants for the halt and timed wakeup sequencer
package htwc_pkg;
	// register indices, byte address is four times the index
	localparam logic [7:0]  IDX_PRESCALER   = 8'h49;
	localparam logic [7:0]  IDX_CTRL_STATUS = 8'h4A;
	localparam logic [7:0]  IDX_MODE_STATUS = 8'h4B;
	localparam int          ADDR_W          = 12;
	// control/status field positions
	localparam int          BIT_ENABLE      = 0;
	localparam int          BIT_MEASURE     = 1;
	localparam int          BIT_FLAG        = 2;
	// reset values
	localparam logic [7:0]  PRESCALER_RST   = 8'hFF;
	localparam logic [2:0]  CTRL_RST        = 3'h0;
	// halt opcode
	localparam logic [7:0]  HALT_OPCODE     = 8'h8E;
	// auto-reload timer clock select that keeps active-halt alive
	localparam logic [1:0]  AT_CLK_ACTIVE   = 2'h1;
	// stabilisation delays in cpu cycles
	localparam logic [9:0]  STARTUP_SHORT   = 10'h100;
	localparam logic [9:0]  STARTUP_LONG    = 10'h200;
	// fixed divider ahead of the prescaler
	localparam int          FIXED_DIV_W     = 6;
	// wake reasons reported to the cpu
	localparam logic [1:0]  SRC_RESET       = 2'h0;
	localparam logic [1:0]  SRC_IRQ         = 2'h1;
	localparam logic [1:0]  SRC_TIMED       = 2'h2;
	localparam logic [1:0]  SRC_TIMER       = 2'h3;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_ACTIVE_HALT,
		ST_HALT,
		ST_TIMED_HALT,
		ST_STARTUP
	} htwc_state_type;
endpackage

// >>> rtl/htwc_ctrl.sv
`timescale 1ns/1ps
module htwc_ctrl
	import htwc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// cpu side
	input  wire logic        opcode_valid,
	input  wire logic [7:0]  opcode,
	input  wire logic        irq_entry,
	input  wire logic        cc_pop,
	input  wire logic        cc_pop_mask,
	output logic             irq_mask,
	output logic             cpu_run,
	output logic             reset_vector_fetch,
	output logic             irq_service,
	output logic [1:0]       wake_source,
	output logic             timed_wake_irq,
	// timers, watchdog and options
	input  wire logic        timebase_irq_enable,
	input  wire logic        overflow_irq_enable,
	input  wire logic [1:0]  autoreload_clk_sel,
	input  wire logic        lite_timer_irq,
	input  wire logic        autoreload_irq,
	input  wire logic        halt_wake_irq,
	input  wire logic        watchdog_active,
	input  wire logic        watchdog_halt_option,
	input  wire logic        long_startup,
	output logic             watchdog_reset,
	// oscillators, pins and clock gates
	input  wire logic        wake_rc_clock,
	input  wire logic        wake_reset_pin,
	output logic             main_osc_en,
	output logic             periph_clk_en,
	output logic             timer_clk_en,
	output logic             wake_osc_en,
	output logic             lite_timer_capture
);

	// reset release through two flip-flops
	logic rst_s1_q;
	logic rst_n_q;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// pin synchronisers, the second stage is read and the rc third stage gives its edge
	logic rc_s1_q;
	logic rc_s2_q;
	logic rc_s3_q;
	logic rstpin_s1_q;
	logic rstpin_s2_q;
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rc_s1_q     <= 1'b0;
			rc_s2_q     <= 1'b0;
			rc_s3_q     <= 1'b0;
			rstpin_s1_q <= 1'b0;
			rstpin_s2_q <= 1'b0;
		end else begin
			rc_s1_q     <= wake_rc_clock;
			rc_s2_q     <= rc_s1_q;
			rc_s3_q     <= rc_s2_q;
			rstpin_s1_q <= wake_reset_pin;
			rstpin_s2_q <= rstpin_s1_q;
		end
	end

	htwc_state_type state_q;
	htwc_state_type state_d;
	logic [7:0]  prescaler_q;
	logic        enable_q;
	logic        measure_q;
	logic        flag_q;
	logic [FIXED_DIV_W-1:0] div_cnt_q;
	logic [7:0]  pre_cnt_q;
	logic [9:0]  stup_cnt_q;
	logic [1:0]  src_q;
	logic        prdy_q;

	// apb decode, answer one cycle into the access phase
	wire        apb_acc    = psel & penable & prdy_q;
	wire [9:0]  word_idx   = paddr[11:2];
	wire        hit_pre    = (word_idx == {2'h0, IDX_PRESCALER});
	wire        hit_ctrl   = (word_idx == {2'h0, IDX_CTRL_STATUS});
	wire        hit_mode   = (word_idx == {2'h0, IDX_MODE_STATUS});
	wire        hit_any    = hit_pre | hit_ctrl | hit_mode;
	wire        wr_pre     = apb_acc & pwrite & hit_pre;
	wire        wr_ctrl    = apb_acc & pwrite & hit_ctrl;
	wire        rd_ctrl    = apb_acc & ~pwrite & hit_ctrl;
	wire [7:0]  ctrl_view  = {5'h00, flag_q, measure_q, enable_q};
	wire [7:0]  mode_view  = {3'h0, src_q, 3'(state_q)};
	wire [7:0]  rd_mux     = hit_pre  ? prescaler_q :
	                         hit_ctrl ? ctrl_view   :
	                         hit_mode ? mode_view   : 8'h00;

	// halt decode and mode selection
	wire halt_exec   = (state_q == ST_RUN) & opcode_valid & (opcode == HALT_OPCODE);
	wire active_en   = timebase_irq_enable |
	                   (overflow_irq_enable & (autoreload_clk_sel == AT_CLK_ACTIVE));
	wire wdg_trip    = watchdog_active & watchdog_halt_option;
	wire halt_enter  = halt_exec & ~wdg_trip;
	wire rc_edge     = rc_s2_q & ~rc_s3_q;
	wire div_wrap    = rc_edge & (div_cnt_q == {FIXED_DIV_W{1'b1}});
	wire timed_done  = div_wrap & ((pre_cnt_q + 8'h01) == prescaler_q);
	wire [9:0] stup_lim = long_startup ? STARTUP_LONG : STARTUP_SHORT;
	wire stup_done   = (stup_cnt_q == stup_lim - 10'h001);
	wire timer_wake  = lite_timer_irq | autoreload_irq;

	// next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_RUN: begin
				if (halt_enter && enable_q)
					state_d = ST_TIMED_HALT;
				else if (halt_enter && active_en)
					state_d = ST_ACTIVE_HALT;
				else if (halt_enter)
					state_d = ST_HALT;
			end
			ST_ACTIVE_HALT: begin
				if (rstpin_s2_q)
					state_d = ST_STARTUP;
				else if (timer_wake)
					state_d = ST_RUN;
			end
			ST_HALT: begin
				if (rstpin_s2_q || halt_wake_irq)
					state_d = ST_STARTUP;
			end
			ST_TIMED_HALT: begin
				if (rstpin_s2_q || halt_wake_irq || timed_done)
					state_d = ST_STARTUP;
			end
			ST_STARTUP: begin
				if (stup_done)
					state_d = ST_RUN;
			end
		endcase
	end

	// wake reason, reset wins over interrupts
	logic [1:0] src_d;
	always_comb begin
		src_d = src_q;
		if (state_q != ST_RUN && state_q != ST_STARTUP && state_d != state_q) begin
			if (rstpin_s2_q)
				src_d = SRC_RESET;
			else if (state_q == ST_ACTIVE_HALT)
				src_d = SRC_TIMER;
			else if (state_q == ST_TIMED_HALT && timed_done)
				src_d = SRC_TIMED;
			else
				src_d = SRC_IRQ;
		end
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= ST_RUN;
			src_q   <= SRC_RESET;
		end else begin
			state_q <= state_d;
			src_q   <= src_d;
		end
	end

	// stabilisation counter, runs only in startup
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q)
			stup_cnt_q <= 10'h000;
		else if (state_q == ST_STARTUP)
			stup_cnt_q <= stup_cnt_q + 10'h001;
		else
			stup_cnt_q <= 10'h000;
	end

	// timed delay: fixed divider then prescaler count
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			div_cnt_q <= '0;
			pre_cnt_q <= 8'h00;
		end else if (state_q != ST_TIMED_HALT) begin
			div_cnt_q <= '0;
			pre_cnt_q <= 8'h00;
		end else if (rc_edge) begin
			div_cnt_q <= div_cnt_q + 1'b1;
			if (div_wrap)
				pre_cnt_q <= pre_cnt_q + 8'h01;
		end
	end

	// software registers; zero prescaler writes are refused
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			prescaler_q <= PRESCALER_RST;
			enable_q    <= CTRL_RST[BIT_ENABLE];
			measure_q   <= CTRL_RST[BIT_MEASURE];
		end else begin
			if (wr_pre && pwdata[7:0] != 8'h00)
				prescaler_q <= pwdata[7:0];
			if (wr_ctrl) begin
				enable_q  <= pwdata[BIT_ENABLE];
				measure_q <= pwdata[BIT_MEASURE];
			end
		end
	end

	// wake flag: set on expiry beats clear on read
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q)
			flag_q <= CTRL_RST[BIT_FLAG];
		else if (state_q == ST_TIMED_HALT && timed_done)
			flag_q <= 1'b1;
		else if (rd_ctrl)
			flag_q <= 1'b0;
	end

	// apb answer registers
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			prdy_q  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			prdy_q  <= psel & penable & ~prdy_q;
			prdata  <= (psel & penable & ~prdy_q & ~pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
			pslverr <= psel & penable & ~prdy_q & ~hit_any;
		end
	end
	assign pready = prdy_q;

	// interrupt mask: halt clears, entry sets, pop restores
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q)
			irq_mask <= 1'b1;
		else if (halt_enter)
			irq_mask <= 1'b0;
		else if (irq_entry)
			irq_mask <= 1'b1;
		else if (cc_pop)
			irq_mask <= cc_pop_mask;
	end

	// clock gates and cpu handshake outputs
	wire leave_stup = (state_q == ST_STARTUP) & stup_done;
	wire act_irq    = (state_q == ST_ACTIVE_HALT) & ~rstpin_s2_q & timer_wake;
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			main_osc_en        <= 1'b1;
			periph_clk_en      <= 1'b1;
			timer_clk_en       <= 1'b1;
			wake_osc_en        <= 1'b0;
			cpu_run            <= 1'b1;
			reset_vector_fetch <= 1'b0;
			irq_service        <= 1'b0;
			wake_source        <= SRC_RESET;
			watchdog_reset     <= 1'b0;
			lite_timer_capture <= 1'b0;
			timed_wake_irq     <= 1'b0;
		end else begin
			main_osc_en        <= (state_d != ST_HALT) & (state_d != ST_TIMED_HALT);
			periph_clk_en      <= (state_d == ST_RUN);
			timer_clk_en       <= (state_d == ST_RUN) | (state_d == ST_ACTIVE_HALT);
			wake_osc_en        <= (state_d == ST_TIMED_HALT) | measure_q;
			cpu_run            <= (state_d == ST_RUN);
			reset_vector_fetch <= leave_stup & (src_q == SRC_RESET);
			irq_service        <= (leave_stup & (src_q != SRC_RESET)) | act_irq;
			wake_source        <= src_d;
			watchdog_reset     <= halt_exec & wdg_trip;
			lite_timer_capture <= measure_q & (state_q == ST_RUN) & rc_s2_q;
			timed_wake_irq     <= flag_q & ~rd_ctrl;
		end
	end

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n_q);

	sequence halt_taken_s;
		halt_enter && !enable_q;
	endsequence

	sequence stup_run_s;
		(state_q == ST_STARTUP)[*8];
	endsequence

	active_entry_a: assert property (halt_taken_s and active_en |=> state_q == ST_ACTIVE_HALT)
		else $error("active-halt not entered");
	plain_entry_a: assert property (halt_taken_s and !active_en |=> state_q == ST_HALT)
		else $error("plain halt not entered");
	timed_entry_a: assert property (halt_enter && enable_q |=> state_q == ST_TIMED_HALT)
		else $error("timed halt not entered");
	act_wake_a: assert property (act_irq |=> state_q == ST_RUN && irq_service && cpu_run)
		else $error("active-halt irq wake not immediate");
	act_block_a: assert property (state_q == ST_ACTIVE_HALT && !timer_wake && !rstpin_s2_q
		|=> state_q == ST_ACTIVE_HALT)
		else $error("active-halt left without cause");
	stup_hold_a: assert property ($rose(state_q == ST_STARTUP) |-> stup_run_s)
		else $error("startup delay too short");
	stup_end_a: assert property (leave_stup |=> state_q == ST_RUN ##0
		(reset_vector_fetch || irq_service))
		else $error("startup did not end in fetch or service");
	mask_clear_a: assert property (halt_enter |=> !irq_mask)
		else $error("mask not cleared on halt");
	osc_off_a: assert property (state_q == ST_HALT |-> !main_osc_en && !periph_clk_en)
		else $error("oscillator running in plain halt");
	act_clk_a: assert property (state_q == ST_ACTIVE_HALT |-> main_osc_en && timer_clk_en
		&& !periph_clk_en)
		else $error("active-halt clocks wrong");
	wdg_trip_a: assert property (halt_exec && wdg_trip |=> watchdog_reset && state_q == ST_RUN)
		else $error("watchdog halt option ignored");
	flag_set_a: assert property (state_q == ST_TIMED_HALT && timed_done |=> flag_q
		&& state_q == ST_STARTUP ##1 timed_wake_irq)
		else $error("timed expiry missed");
	flag_read_a: assert property (rd_ctrl && !(state_q == ST_TIMED_HALT && timed_done) |=> !flag_q)
		else $error("read did not clear flag");
	flag_write_a: assert property (wr_ctrl && state_q != ST_TIMED_HALT |=> $stable(flag_q))
		else $error("write changed flag");
	pre_zero_a: assert property (wr_pre && pwdata[7:0] == 8'h00 |=> $stable(prescaler_q))
		else $error("zero prescaler accepted");
	timed_div_a: assert property (state_q == ST_TIMED_HALT && rc_edge && div_cnt_q != {FIXED_DIV_W{1'b1}}
		|=> $stable(pre_cnt_q))
		else $error("prescaler stepped before fixed divider");

endmodule // htwc_ctrl

// >>> test/htwc_partner.sv
`timescale 1ns/1ps
// far side: wake rc oscillator and the cpu's interrupt entry
module htwc_partner (
	input  wire logic mclk,
	input  wire logic wake_osc_en,
	input  wire logic irq_service,
	output logic      wake_rc_clock,
	output logic      irq_entry
);
	// rc runs only while enabled, otherwise it stands still low
	initial begin
		wake_rc_clock = 1'b0;
		forever begin
			#18.5;
			wake_rc_clock = wake_osc_en ? ~wake_rc_clock : 1'b0;
		end
	end
	// cpu enters the routine one cycle after a service request
	initial irq_entry = 1'b0;
	always @(posedge mclk) irq_entry <= irq_service;
endmodule // htwc_partner

// >>> test/test_halt_and_timed_wakeup_control.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("Error %0t got %h exp %h", $time, g, e); end end
module test_halt_and_timed_wakeup_control;
	import htwc_pkg::*;
	logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, opcode_valid, irq_entry, cc_pop, cc_pop_mask;
	logic        irq_mask, cpu_run, reset_vector_fetch, irq_service, timed_wake_irq, timebase_irq_enable;
	logic        overflow_irq_enable, lite_timer_irq, autoreload_irq, halt_wake_irq, watchdog_active;
	logic        watchdog_halt_option, watchdog_reset, wake_rc_clock, wake_reset_pin, main_osc_en;
	logic        periph_clk_en, timer_clk_en, wake_osc_en, lite_timer_capture, er, cap_last, long_st;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [7:0]  opcode;
	logic [1:0]  wake_source, autoreload_clk_sel;
	int          bad_count, n_tests, wd_seen, rc_cnt, cap_tg, n, rc0, pre, m_pre, m_ctrl, m_rd;

	htwc_ctrl dut_u (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .opcode_valid(opcode_valid),
		.opcode(opcode), .irq_entry(irq_entry), .cc_pop(cc_pop), .cc_pop_mask(cc_pop_mask), .irq_mask(irq_mask),
		.cpu_run(cpu_run), .reset_vector_fetch(reset_vector_fetch), .irq_service(irq_service),
		.wake_source(wake_source), .timed_wake_irq(timed_wake_irq), .timebase_irq_enable(timebase_irq_enable),
		.overflow_irq_enable(overflow_irq_enable), .autoreload_clk_sel(autoreload_clk_sel),
		.lite_timer_irq(lite_timer_irq), .autoreload_irq(autoreload_irq), .halt_wake_irq(halt_wake_irq),
		.watchdog_active(watchdog_active), .watchdog_halt_option(watchdog_halt_option), .long_startup(long_st),
		.watchdog_reset(watchdog_reset), .wake_rc_clock(wake_rc_clock), .wake_reset_pin(wake_reset_pin),
		.main_osc_en(main_osc_en), .periph_clk_en(periph_clk_en), .timer_clk_en(timer_clk_en),
		.wake_osc_en(wake_osc_en), .lite_timer_capture(lite_timer_capture));
	htwc_partner partner_u (.mclk(mclk), .wake_osc_en(wake_osc_en), .irq_service(irq_service),
		.wake_rc_clock(wake_rc_clock), .irq_entry(irq_entry));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// event monitors
	always @(posedge mclk) if (watchdog_reset === 1'b1) wd_seen++;
	always @(posedge wake_rc_clock) rc_cnt++;
	always @(posedge mclk) if (lite_timer_capture !== cap_last) begin cap_tg++; cap_last = lite_timer_capture; end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		int k;
		@(posedge mclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {2'b00, idx, 2'b00}; pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do begin @(posedge mclk); k++; end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin bad_count++; tally_and_finish(); end
		rd = prdata; er = pslverr;
		// register model: expected read, then the effect of the transfer
		m_rd = (idx == IDX_PRESCALER) ? m_pre : (idx == IDX_CTRL_STATUS) ? m_ctrl : 0;
		if (!w && idx != IDX_MODE_STATUS) `CHK(rd, m_rd)
		if (w && idx == IDX_PRESCALER && wd[7:0] != 8'h00) m_pre = wd[7:0];
		if (w && idx == IDX_CTRL_STATUS) m_ctrl = (m_ctrl & 4) | (wd & 3);
		if (!w && idx == IDX_CTRL_STATUS) m_ctrl = m_ctrl & 3;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	// cpu clock already slowed by software before any halt
	task automatic do_halt(input logic [7:0] op);
		@(posedge mclk);
		opcode_valid <= 1'b1; opcode <= op;
		@(posedge mclk);
		opcode_valid <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wait_hi(ref logic s, output int c);
		c = 0;
		while (s !== 1'b1 && c < 3000) begin @(posedge mclk); c++; end
		if (c >= 3000) begin bad_count++; tally_and_finish(); end
	endtask
	task automatic mode(input logic [2:0] st);
		apb(1'b0, IDX_MODE_STATUS, 32'h0);
		`CHK(rd[2:0], st)
	endtask

	initial begin
		{psel, penable, pwrite, opcode_valid, cc_pop, cc_pop_mask, timebase_irq_enable, overflow_irq_enable} = '0;
		{lite_timer_irq, autoreload_irq, halt_wake_irq, watchdog_active, watchdog_halt_option, wake_reset_pin} = '0;
		{paddr, pwdata, opcode, autoreload_clk_sel, cap_last, long_st} = '0;
		seed = 32'hB5FB6E0C; reset_n = 1'b0; m_pre = 255; m_ctrl = 0;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		// reset values, unmapped access, refused writes
		`CHK(irq_mask, 1'b1)
		apb(1'b0, IDX_PRESCALER, 32'h0); `CHK(rd, 32'h0000_00FF)
		apb(1'b0, 8'h10, 32'h0); `CHK({er, rd}, 33'h1_0000_0000)
		apb(1'b1, IDX_PRESCALER, 32'h0); apb(1'b0, IDX_PRESCALER, 32'h0); `CHK(rd, 32'h0000_00FF)
		seed = lfsr(seed); pre = seed % 3 + 1;
		apb(1'b1, IDX_PRESCALER, pre); apb(1'b0, IDX_PRESCALER, 32'h0); `CHK(rd, pre)
		apb(1'b1, IDX_CTRL_STATUS, 32'h4); apb(1'b0, IDX_CTRL_STATUS, 32'h0); `CHK(rd, 32'h0)
		$display("test registers done");
		// other opcodes never halt
		repeat (3) begin
			seed = lfsr(seed);
			do_halt(seed[7:0] == HALT_OPCODE ? 8'h00 : seed[7:0]);
			mode(3'h0);
		end
		// active-halt from the timebase enable, ignores halt irqs, wakes at once on timer irq
		timebase_irq_enable <= 1'b1;
		do_halt(HALT_OPCODE); mode(3'h1);
		`CHK({irq_mask, main_osc_en, timer_clk_en, periph_clk_en}, 4'b0110)
		halt_wake_irq <= 1'b1; repeat (20) @(posedge mclk); halt_wake_irq <= 1'b0;
		mode(3'h1);
		lite_timer_irq <= 1'b1; wait_hi(irq_service, n); lite_timer_irq <= 1'b0;
		`CHK(n <= 3, 1'b1)
		`CHK({cpu_run, wake_source}, {1'b1, SRC_TIMER})
		repeat (2) @(posedge mclk);
		`CHK(irq_mask, 1'b1)
		cc_pop <= 1'b1; @(posedge mclk); cc_pop <= 1'b0; repeat (2) @(posedge mclk);
		`CHK(irq_mask, 1'b0)
		$display("test active halt done");
		// active-halt through overflow enable with select 01, reset wake
		timebase_irq_enable <= 1'b0; overflow_irq_enable <= 1'b1; autoreload_clk_sel <= AT_CLK_ACTIVE;
		do_halt(HALT_OPCODE); mode(3'h1);
		wake_reset_pin <= 1'b1; wait_hi(reset_vector_fetch, n); wake_reset_pin <= 1'b0;
		`CHK(n inside {[256:264]}, 1'b1)
		$display("test reset wake done");
		// select 11 gives plain halt; halt irq wakes after the startup delay
		autoreload_clk_sel <= 2'h3;
		do_halt(HALT_OPCODE); mode(3'h2);
		`CHK({irq_mask, main_osc_en, periph_clk_en, timer_clk_en}, 4'b0000)
		halt_wake_irq <= 1'b1; wait_hi(main_osc_en, n); halt_wake_irq <= 1'b0;
		`CHK(n <= 4, 1'b1)
		wait_hi(irq_service, n); `CHK(n inside {[250:260]}, 1'b1)
		`CHK(wake_source, SRC_IRQ)
		overflow_irq_enable <= 1'b0;
		$display("test plain halt done");
		// watchdog option decides between reset and halt
		watchdog_active <= 1'b1; watchdog_halt_option <= 1'b1;
		do_halt(HALT_OPCODE); mode(3'h0); `CHK(wd_seen, 1)
		watchdog_halt_option <= 1'b0; timebase_irq_enable <= 1'b1;
		do_halt(HALT_OPCODE); mode(3'h1); `CHK(wd_seen, 1)
		lite_timer_irq <= 1'b1; wait_hi(irq_service, n); lite_timer_irq <= 1'b0;
		watchdog_active <= 1'b0;
		$display("test watchdog done");
		// timed wakeup beats active-halt; 64 rc edges per prescaler step
		apb(1'b1, IDX_CTRL_STATUS, 32'h1);
		rc0 = rc_cnt;
		do_halt(HALT_OPCODE); mode(3'h3);
		`CHK({main_osc_en, wake_osc_en}, 2'b01)
		wait_hi(main_osc_en, n); `CHK((rc_cnt - rc0) inside {[64 * pre : 64 * pre + 2]}, 1'b1)
		wait_hi(timed_wake_irq, n);
		m_ctrl = m_ctrl | 4;
		wait_hi(irq_service, n); `CHK(n inside {[250:260]}, 1'b1)
		`CHK(wake_source, SRC_TIMED)
		apb(1'b0, IDX_CTRL_STATUS, 32'h0); `CHK(rd, 32'h5)
		apb(1'b0, IDX_CTRL_STATUS, 32'h0); `CHK({timed_wake_irq, rd}, 33'h1)
		$display("test timed wakeup done");
		// second reset with the long startup strap; timed halt ended early by a halt irq
		reset_n <= 1'b0; long_st <= 1'b1;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1; m_pre = 255; m_ctrl = 0;
		repeat (3) @(posedge mclk);
		`CHK({irq_mask, cpu_run, main_osc_en, wake_source}, {3'b111, SRC_RESET})
		apb(1'b1, IDX_CTRL_STATUS, 32'h1);
		do_halt(HALT_OPCODE); mode(3'h3);
		halt_wake_irq <= 1'b1; wait_hi(irq_service, n); halt_wake_irq <= 1'b0;
		`CHK(n inside {[508:516]}, 1'b1)
		`CHK(wake_source, SRC_IRQ)
		apb(1'b1, IDX_CTRL_STATUS, 32'h0);
		$display("test long startup done");
		// measure bit routes the rc clock to the capture input
		apb(1'b1, IDX_CTRL_STATUS, 32'h2); cap_tg = 0;
		repeat (200) @(posedge mclk);
		`CHK(cap_tg > 4, 1'b1)
		apb(1'b1, IDX_CTRL_STATUS, 32'h0);
		$display("test measure done");
		tally_and_finish();
	end
endmodule // test_halt_and_timed_wakeup_control
